// ===== rcf_pkg.sv
/*
  Package for the reset-cause flag register: register address, bit
  positions, request carriers, state record and timing counts.
  Assumes a single 250 MHz clock and an 8-bit special-register space.
*/
`default_nettype none

package rcf_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register address and bit positions
  localparam logic [7:0] RCF_ADDR = 8'hef;
  localparam int unsigned BIT_PIN = 0;
  localparam int unsigned BIT_POR = 1;
  localparam int unsigned BIT_MCD = 2;
  localparam int unsigned BIT_WDT = 3;
  localparam int unsigned BIT_SW = 4;
  localparam int unsigned BIT_COMP = 5;
  localparam int unsigned BIT_FERR = 6;
  localparam logic [7:0] F_PIN = 8'(1 << BIT_PIN);
  localparam logic [7:0] F_POR = 8'(1 << BIT_POR);
  localparam logic [7:0] F_MCD = 8'(1 << BIT_MCD);
  localparam logic [7:0] F_WDT = 8'(1 << BIT_WDT);
  localparam logic [7:0] F_SW = 8'(1 << BIT_SW);
  localparam logic [7:0] F_COMP = 8'(1 << BIT_COMP);
  localparam logic [7:0] F_FERR = 8'(1 << BIT_FERR);

  // Highest legal flash address for user code
  localparam logic [15:0] FLASH_LIMIT = 16'h3dff;

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser slots for inputs from outside the clock domain
  localparam int unsigned S_PIN = 0;
  localparam int unsigned S_COMP = 1;
  localparam int unsigned S_VDD = 2;
  localparam int unsigned S_SCLK = 3;
  localparam int unsigned SYNC_N = 4;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MCD_TIMEOUT_NS = 100000;
  localparam logic [15:0] MCD_TIMEOUT_CYC =
    16'((MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RESET_HOLD_NS = 32;
  localparam logic [3:0] RESET_HOLD_CYC =
    4'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rcf_sfr_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic fetch;
    logic wr_en;
    logic sec_viol;
  } rcf_flash_req_s;

  typedef struct packed {
    logic [SYNC_N-1:0][2:0] sync;
    logic [SYNC_N-1:0] level;
    logic [7:0] flags;
    logic comp_en;
    logic mcd_en;
    logic vdd_sel;
    logic [15:0] mcd_cnt;
    logic [3:0] hold_cnt;
    logic sys_reset;
    logic [7:0] rdata;
  } rcf_state_s;

  // Power-on state: cause is power-on, system held in reset
  localparam rcf_state_s STATE_RST = '{
    sync: '1, level: '1, flags: F_POR, comp_en: 1'b0, mcd_en: 1'b0,
    vdd_sel: 1'b1, mcd_cnt: 16'h0000, hold_cnt: 4'(RESET_HOLD_CYC - 4'h1),
    sys_reset: 1'b1, rdata: 8'h00};

endpackage : rcf_pkg

`default_nettype wire

// ===== rcf_reset_cause.sv
/*
  Reset-cause flag register with its reset sources and the system reset
  pulse it generates. ARST_N is the power-on reset of this block; only the
  causing flag survives every other reset. Pin, comparator, supply-good and the
  monitored system clock arrive asynchronously; the rest is on CLK.
*/
`default_nettype none

module rcf_reset_cause
  import rcf_pkg::*;
#(
  parameter logic [15:0] MCD_TIMEOUT_CYCLES = MCD_TIMEOUT_CYC
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire rcf_sfr_req_s SFR_REQ,
  output logic [7:0] SFR_RDATA,
  input wire rcf_flash_req_s FLASH_REQ,
  input wire logic WDT_OVERFLOW,
  input wire logic VDD_MON_ON,
  input wire logic VDD_ABOVE,
  input wire logic COMP_OUT,
  input wire logic RST_PIN_N,
  input wire logic SYSCLK_MON,
  output logic SYS_RESET
);

  rcf_state_s s;
  rcf_state_s next_s;
  logic [SYNC_N-1:0] raw;
  logic pin_low;
  logic sclk_edge;
  logic sfr_hit;
  logic wr_ok;
  logic trig_pin;
  logic trig_vdd;
  logic trig_mcd;
  logic trig_comp;
  logic trig_wdt;
  logic trig_ferr;
  logic trig_sw;
  logic [7:0] cause;
  logic [7:0] readback;

  //////////////////////////////////////////////////////////////////////////
  // Source conditions; pin, supply-good and comparator are judged on settled synchroniser levels
  assign raw = {SYSCLK_MON, VDD_ABOVE, COMP_OUT, RST_PIN_N};
  assign pin_low = !s.level[S_PIN];
  assign sclk_edge = (s.sync[S_SCLK][2] == s.sync[S_SCLK][1])
                     && (s.sync[S_SCLK][2] != s.level[S_SCLK]);
  assign sfr_hit = SFR_REQ.addr == RCF_ADDR;
  // Writes during reset are dropped: the core is held anyway
  assign wr_ok = sfr_hit && SFR_REQ.wr && !s.sys_reset;
  assign trig_pin = pin_low;
  assign trig_vdd = s.vdd_sel && VDD_MON_ON
                    && !s.level[S_VDD];
  assign trig_mcd = s.mcd_en
                    && (s.mcd_cnt == 16'(MCD_TIMEOUT_CYCLES - 16'h0001));
  assign trig_comp = s.comp_en && !s.level[S_COMP];
  assign trig_wdt = WDT_OVERFLOW;
  assign trig_ferr = FLASH_REQ.sec_viol
                     || ((FLASH_REQ.addr > FLASH_LIMIT)
                         && (FLASH_REQ.rd || FLASH_REQ.fetch
                             || (FLASH_REQ.wr && FLASH_REQ.wr_en)));
  assign trig_sw = wr_ok && SFR_REQ.wdata[BIT_SW];

  // Combined enable/flag bits read back the live enable as well
  assign readback = {1'b0, s.flags[BIT_FERR],
                     s.flags[BIT_COMP] | s.comp_en,
                     s.flags[BIT_SW], s.flags[BIT_WDT],
                     s.flags[BIT_MCD] | s.mcd_en,
                     s.flags[BIT_POR], s.flags[BIT_PIN]};

  //////////////////////////////////////////////////////////////////////////
  // One-hot cause; fixed priority settles simultaneous sources
  always_comb begin
    cause = 8'h00;
    if (trig_pin) begin
      cause = F_PIN;
    end else if (trig_vdd) begin
      cause = F_POR;
    end else if (trig_mcd) begin
      cause = F_MCD;
    end else if (trig_comp) begin
      cause = F_COMP;
    end else if (trig_wdt) begin
      cause = F_WDT;
    end else if (trig_ferr) begin
      cause = F_FERR;
    end else if (trig_sw) begin
      cause = F_SW;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    // Three-stage synchronisers; a level counts once stages 2 and 3 agree
    for (int i = 0; i < SYNC_N; i++) begin
      next_s.sync[i] = {s.sync[i][1:0], raw[i]};
      if (s.sync[i][2] == s.sync[i][1]) begin
        next_s.level[i] = s.sync[i][2];
      end
    end
    if (s.sys_reset) begin
      // Pin held low keeps the system in reset until release
      next_s.mcd_cnt = 16'h0000;
      if (pin_low) begin
        next_s.hold_cnt = 4'(RESET_HOLD_CYC - 4'h1);
      end else if (s.hold_cnt != 4'h0) begin
        next_s.hold_cnt = 4'(s.hold_cnt - 4'h1);
      end else begin
        next_s.sys_reset = 1'b0;
      end
    end else if (cause != 8'h00) begin
      // Only the causing flag survives; detector and comparator drop out
      next_s.flags = cause;
      next_s.sys_reset = 1'b1;
      next_s.hold_cnt = 4'(RESET_HOLD_CYC - 4'h1);
      next_s.comp_en = 1'b0;
      next_s.mcd_en = 1'b0;
      next_s.mcd_cnt = 16'h0000;
    end else begin
      if (wr_ok) begin
        next_s.comp_en = SFR_REQ.wdata[BIT_COMP];
        next_s.mcd_en = SFR_REQ.wdata[BIT_MCD];
        next_s.vdd_sel = SFR_REQ.wdata[BIT_POR];
      end
      // Cycles since last system clock edge, only while enabled
      if (sclk_edge || !s.mcd_en) begin
        next_s.mcd_cnt = 16'h0000;
      end else begin
        next_s.mcd_cnt = 16'(s.mcd_cnt + 16'h0001);
      end
    end
    // Read data is registered; unaddressed cycles return zero
    if (sfr_hit && SFR_REQ.rd && !s.sys_reset) begin
      next_s.rdata = readback;
    end else begin
      next_s.rdata = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register; power-on reset sets the power-on cause alone
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign SFR_RDATA = s.rdata;
  assign SYS_RESET = s.sys_reset;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  chk_flash_error: assert property (
    (!s.sys_reset && trig_ferr && !trig_pin && !trig_vdd && !trig_mcd
     && !trig_comp && !trig_wdt) |=> (s.sys_reset && s.flags == F_FERR))
    else $error("flash error did not reset with its flag");

  chk_comp_enable: assert property (
    (wr_ok && cause == 8'h00)
    |=> (s.comp_en == $past(SFR_REQ.wdata[BIT_COMP])))
    else $error("comparator enable not taken from write");

  chk_comp_reset: assert property (
    (!s.sys_reset && trig_comp && !trig_pin && !trig_vdd && !trig_mcd)
    |=> (s.flags == F_COMP && !s.comp_en) ##1 (s.sys_reset [*7]))
    else $error("comparator reset flag or hold wrong");

  chk_sw_force: assert property (
    (trig_sw && cause == F_SW) |=> (s.sys_reset && s.flags == F_SW))
    else $error("software reset not forced");

  chk_flags_ro: assert property (
    (wr_ok && cause == 8'h00) |=> (s.flags == $past(s.flags)))
    else $error("write changed a cause flag");

  chk_mcd_enable: assert property (
    (wr_ok && cause == 8'h00) |=> (s.mcd_en == $past(SFR_REQ.wdata[BIT_MCD])))
    else $error("detector enable not taken from write");

  chk_mcd_timeout: assert property (
    (!s.sys_reset && trig_mcd && !trig_pin && !trig_vdd)
    |=> (s.sys_reset && s.flags == F_MCD))
    else $error("missing clock timeout did not reset");

  chk_vdd_reset: assert property (
    (!s.sys_reset && trig_vdd && !trig_pin) |=> (s.flags == F_POR))
    else $error("supply reset did not set power-on flag");

  chk_vdd_gate: assert property (
    (!s.sys_reset && !(s.vdd_sel && VDD_MON_ON) && !trig_pin && !trig_mcd
     && !trig_comp && !trig_wdt && !trig_ferr && !trig_sw) |=> !s.sys_reset)
    else $error("reset without any selected source");

  chk_pin_hold: assert property (
    (pin_low && !s.sys_reset) |=> (s.sys_reset && s.flags == F_PIN))
    else $error("pin reset not taken");

  chk_onehot_cause: assert property (
    $rose(s.sys_reset) |-> ($onehot(s.flags) && s.sys_reset [*8]))
    else $error("cause not one-hot or hold too short");

  chk_bit7_zero: assert property (
    $past(sfr_hit && SFR_REQ.rd && !s.sys_reset) |-> (SFR_RDATA[7] == 1'b0
      && SFR_RDATA[BIT_FERR] == $past(s.flags[BIT_FERR])))
    else $error("read-back of bit 7 or flash flag wrong");

endmodule : rcf_reset_cause

`default_nettype wire

// ===== rcf_reset_cause_bench.sv
/*
  Self-checking bench for the reset-cause flag register: register
  accesses, each reset source and the flags they leave behind.
  Assumes rcf_pkg is compiled first; the bench drives all inputs itself.
*/
`default_nettype none

module rcf_reset_cause_bench
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  rcf_sfr_req_s SFR_REQ = '0;
  rcf_flash_req_s FLASH_REQ = '0;
  logic WDT_OVERFLOW = 1'b0;
  logic VDD_MON_ON = 1'b1;
  logic VDD_ABOVE = 1'b1;
  logic COMP_OUT = 1'b1;
  logic RST_PIN_N = 1'b1;
  logic SYSCLK_MON = 1'b0;
  logic sclk_run = 1'b1;
  logic [7:0] SFR_RDATA;
  logic SYS_RESET;
  int num_errors = 0;
  int checks = 0;
  int hi_cnt;
  // Flash table: address, {rd, wr, fetch, wr_en, sec_viol}, reset expected
  logic [21:0] ftbl [6] = '{{16'h3dff, 5'h10, 1'b0}, {16'h3e00, 5'h08, 1'b0},
    {16'h3e00, 5'h10, 1'b1}, {16'h3e00, 5'h04, 1'b1},
    {16'h3e00, 5'h0a, 1'b1}, {16'h0100, 5'h01, 1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // Short timeout keeps the missing-clock runs brief
  rcf_reset_cause #(.MCD_TIMEOUT_CYCLES(16'h0014)) u_dut (
    .CLK(CLK), .ARST_N(ARST_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
    .FLASH_REQ(FLASH_REQ), .WDT_OVERFLOW(WDT_OVERFLOW),
    .VDD_MON_ON(VDD_MON_ON),
    .VDD_ABOVE(VDD_ABOVE), .COMP_OUT(COMP_OUT), .RST_PIN_N(RST_PIN_N),
    .SYSCLK_MON(SYSCLK_MON), .SYS_RESET(SYS_RESET));

  // Clocks; the watched clock toggles on odd nanoseconds, never on a
  // CLK edge, so its sampling is free of races
  always #2 CLK = ~CLK;
  initial begin
    #1;
    forever #10 if (sclk_run) SYSCLK_MON = ~SYSCLK_MON;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Requests go out at the falling edge and are taken at the next rise
  task automatic sfr_write(input logic [7:0] d);
    @(negedge CLK);
    SFR_REQ = '{addr: RCF_ADDR, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge CLK);
    SFR_REQ = '0;
  endtask : sfr_write

  // Read data stands for the one cycle after the take edge
  task automatic sfr_read(input logic [7:0] exp);
    @(negedge CLK);
    SFR_REQ = '{addr: RCF_ADDR, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge CLK);
    SFR_REQ = '0;
    check("reset_cause_register", exp, SFR_RDATA);
  endtask : sfr_read

  task automatic wait_hi(input int lim);
    for (int i = 0; i < lim && SYS_RESET !== 1'b1; i++) @(negedge CLK);
    check("sys_reset_rise", 8'h01, {7'h00, SYS_RESET});
  endtask : wait_hi

  // Counts falling edges with reset high; next request one cycle later
  task automatic wait_lo();
    hi_cnt = 0;
    while (SYS_RESET === 1'b1 && hi_cnt < 60) begin
      hi_cnt++;
      @(negedge CLK);
    end
    check("sys_reset_fall", 8'h00, {7'h00, SYS_RESET});
    @(negedge CLK);
  endtask : wait_lo

  task automatic no_rst(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge CLK);
      bad |= (SYS_RESET !== 1'b0);
    end
    check("no_reset", 8'h00, {7'h00, bad});
  endtask : no_rst

  task automatic conclude();
    $display("num_errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    conclude();
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge CLK);
    ARST_N = 1'b1;
    wait_lo();
    sfr_read(8'h02);
    sfr_write(8'h24);
    sfr_read(8'h26);
    no_rst(30);
    sfr_write(8'h10);
    check("sys_reset_now", 8'h01, {7'h00, SYS_RESET});
    wait_lo();
    check("reset_hold", 8'h08, 8'(hi_cnt));
    sfr_read(8'h10);
    // Read-only bits and bit 7 must ignore this write
    sfr_write(8'h89);
    sfr_read(8'h10);
    @(negedge CLK) WDT_OVERFLOW = 1'b1;
    @(negedge CLK) WDT_OVERFLOW = 1'b0;
    wait_hi(3);
    wait_lo();
    sfr_read(8'h08);
    // Comparator low while not enabled must be harmless
    COMP_OUT = 1'b0;
    no_rst(10);
    COMP_OUT = 1'b1;
    repeat (6) @(negedge CLK);
    sfr_write(8'h20);
    COMP_OUT = 1'b0;
    wait_hi(10);
    COMP_OUT = 1'b1;
    wait_lo();
    sfr_read(8'h20);
    // Detector switched on then off: a stopped clock is ignored
    sfr_write(8'h04);
    sfr_write(8'h00);
    sclk_run = 1'b0;
    no_rst(40);
    sclk_run = 1'b1;
    repeat (8) @(negedge CLK);
    sfr_write(8'h04);
    sfr_read(8'h24);
    sclk_run = 1'b0;
    wait_hi(40);
    sclk_run = 1'b1;
    wait_lo();
    sfr_read(8'h04);
    for (int i = 0; i < 6; i++) begin
      @(negedge CLK) FLASH_REQ = rcf_flash_req_s'(ftbl[i][21:1]);
      @(negedge CLK) FLASH_REQ = '0;
      if (ftbl[i][0]) begin
        wait_hi(3);
        wait_lo();
        sfr_read(8'h40);
      end else begin
        no_rst(6);
      end
    end
    // Supply low: selected with monitor off, then monitor on unselected
    VDD_MON_ON = 1'b0;
    VDD_ABOVE = 1'b0;
    sfr_write(8'h02);
    no_rst(10);
    sfr_write(8'h00);
    VDD_MON_ON = 1'b1;
    no_rst(10);
    sfr_write(8'h02);
    wait_hi(4);
    VDD_ABOVE = 1'b1;
    wait_lo();
    sfr_read(8'h02);
    RST_PIN_N = 1'b0;
    repeat (6) @(negedge CLK);
    check("pin_reset", 8'h01, {7'h00, SYS_RESET});
    RST_PIN_N = 1'b1;
    wait_lo();
    sfr_read(8'h01);
    // Second power-on reset mid-run: power-on cause alone, enables off
    sfr_write(8'h24);
    ARST_N = 1'b0;
    @(negedge CLK);
    check("por_reset", 8'h01, {7'h00, SYS_RESET});
    ARST_N = 1'b1;
    wait_lo();
    check("por_hold", 8'h08, 8'(hi_cnt));
    sfr_read(8'h02);
    conclude();
  end

endmodule : rcf_reset_cause_bench

`default_nettype wire
